// >>> shared/acp_pkg.sv
package acp_pkg;
	localparam int DATA_W       = 8;
	localparam int PHY_AW       = 2;
	localparam int LEN_W        = 7;
	localparam int CELL_STD     = 53;
	localparam int CELL_MAX     = 64;
	localparam int CONN_INT     = 32;
	localparam int CONN_AW      = 5;
	localparam int KEY_W        = 24;
	localparam int EXT_AW       = 16;
	localparam int SYNC_LAT     = 3;
	localparam int CLK_NS       = 100;
	localparam int PACE_TICK_NS = 1000;
	localparam int PACE_TICK_CYC = (PACE_TICK_NS / CLK_NS) < 1 ? 1 : PACE_TICK_NS / CLK_NS;
	localparam int PACE_MAX     = 15;
	localparam int HDR_LAST     = 3;

	typedef enum logic [1:0] {
		ACP_IDLE = 2'b00,
		ACP_POLL = 2'b01,
		ACP_RX   = 2'b11,
		ACP_TX   = 2'b10
	} acp_state_t;
endpackage : acp_pkg

// >>> shared/acp_ser_if.sv
`timescale 1ns/100ps
interface acp_ser_if;
	logic [7:0] data;
	logic       valid;
	logic       frame;
	modport src (output data, output valid, output frame);
	modport dst (input data, input valid, input frame);
endinterface : acp_ser_if

// >>> rtl/acp_ser_bytes.sv
`timescale 1ns/100ps
module acp_ser_bytes (
	input  wire logic clock,    // system clock
	input  wire logic nrst,     // sync reset, active low
	input  wire logic ser_clk,  // serial bit clock pin
	input  wire logic ser_rxd,  // serial data pin
	input  wire logic ser_bsync,// byte boundary, high with first bit
	input  wire logic ser_fsync,// frame sync, high with first bit of frame
	acp_ser_if.src    bytes     // assembled bytes
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] s1, s2, s3, next_s1, next_s2, next_s3;
	logic       clk_f, next_clk_f;
	logic [6:0] shift, next_shift;
	logic [2:0] bits, next_bits;
	logic       fr, next_fr;
	logic [7:0] data, next_data;
	logic       valid, next_valid;
	logic       frame, next_frame;
	logic       rise;

	always_comb begin
		next_s1    = {ser_clk, ser_rxd, ser_bsync, ser_fsync};
		next_s2    = s1;
		next_s3    = s2;
		next_clk_f = (s2[3] == s3[3]) ? s3[3] : clk_f;
		rise       = (s2[3] == s3[3]) && s3[3] && !clk_f;
		next_shift = shift;
		next_bits  = bits;
		next_fr    = fr;
		next_data  = data;
		next_valid = 1'b0;
		next_frame = frame;
		if (rise) begin
			if (s3[1]) begin
				next_bits  = 3'h1;
				next_shift = {6'h00, s3[2]};
				next_fr    = s3[0];
			end else begin
				next_bits  = bits + 3'h1;
				next_shift = {shift[5:0], s3[2]};
			end
			if (!s3[1] && bits == 3'h7) begin
				next_data  = {shift, s3[2]};
				next_valid = 1'b1;
				next_frame = fr;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s1 <= 4'h0; s2 <= 4'h0; s3 <= 4'h0;
			clk_f <= 1'b0; shift <= 7'h00; bits <= 3'h0; fr <= 1'b0;
			data <= 8'h00; valid <= 1'b0; frame <= 1'b0;
		end else begin
			s1 <= next_s1; s2 <= next_s2; s3 <= next_s3;
			clk_f <= next_clk_f; shift <= next_shift; bits <= next_bits; fr <= next_fr;
			data <= next_data; valid <= next_valid; frame <= next_frame;
		end
	end

	assign bytes.data  = data;
	assign bytes.valid = valid;
	assign bytes.frame = frame;
endmodule : acp_ser_bytes

// >>> rtl/acp_cell_port.sv
`timescale 1ns/100ps
module acp_cell_port #(
	parameter int PACE_DIV = acp_pkg::PACE_TICK_CYC, // clocks per pace tick
	parameter int NUM_CONN = acp_pkg::CONN_INT       // internal table entries
) (
	input  wire logic        clock,          // 10 MHz system clock
	input  wire logic        nrst,           // sync reset, active low
	input  wire logic        port_enable,    // cell port configured and on
	input  wire logic        serial_mode,    // receive from serial path
	input  wire logic [1:0]  num_phy,        // highest PHY index polled
	input  wire logic [6:0]  cell_len,       // cell bytes, 53..64
	input  wire logic        ext_cam_mode,   // external misses go to CAM
	output logic      [7:0]  utp_txdata,     // cell data to PHY
	output logic             utp_txsoc,      // first byte of tx cell
	output logic             utp_txenb_n,    // tx enable, active low
	input  wire logic        utp_txclav,     // PHY can take a cell
	input  wire logic [7:0]  utp_rxdata,     // cell data from PHY
	input  wire logic        utp_rxsoc,      // first byte of rx cell
	output logic             utp_rxenb_n,    // rx enable, active low
	input  wire logic        utp_rxclav,     // PHY holds a cell
	output logic      [1:0]  utp_phy_addr,   // selected PHY
	input  wire logic        ser_clk,        // serial bit clock pin
	input  wire logic        ser_rxd,        // serial data pin
	input  wire logic        ser_bsync,      // serial byte boundary pin
	input  wire logic        ser_fsync,      // serial frame sync pin
	input  wire logic        tx_cell_avail,  // a whole cell is staged
	input  wire logic [7:0]  tx_data,        // tx byte, taken with tx_ready
	output logic             tx_ready,       // tx byte taken this cycle
	output logic      [7:0]  rx_data,        // received byte to DMA
	output logic             rx_valid,       // rx_data valid pulse
	output logic             rx_sop,         // first byte of cell
	output logic      [1:0]  rx_phy,         // PHY the cell came from
	input  wire logic        tbl_we,         // write table entry
	input  wire logic [4:0]  tbl_idx,        // entry index
	input  wire logic [23:0] tbl_key,        // connection key
	input  wire logic        tbl_entry_valid,// entry in use
	output logic             conn_done,      // lookup finished pulse
	output logic             conn_hit,       // found in internal table
	output logic      [4:0]  conn_idx,       // internal entry index
	output logic             ext_req,        // external lookup request pulse
	output logic             ext_cam,        // request is for the CAM
	output logic      [15:0] ext_addr,       // compressed external address
	output logic      [23:0] ext_key,        // key for external lookup
	output logic             eth_disable,    // ethernet channel blocked
	output logic             portd_cell_sel  // port D carries cell signals
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [10:0] s1, s2, s3, next_s1, next_s2, next_s3;
	logic        rxclav_f, txclav_f, next_rxclav_f, next_txclav_f;

	always_comb begin
		next_s1       = {utp_rxclav, utp_txclav, utp_rxsoc, utp_rxdata};
		next_s2       = s1;
		next_s3       = s2;
		next_rxclav_f = (s2[10] == s3[10]) ? s3[10] : rxclav_f;
		next_txclav_f = (s2[9] == s3[9]) ? s3[9] : txclav_f;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s1 <= 11'h000; s2 <= 11'h000; s3 <= 11'h000;
			rxclav_f <= 1'b0; txclav_f <= 1'b0;
		end else begin
			s1 <= next_s1; s2 <= next_s2; s3 <= next_s3;
			rxclav_f <= next_rxclav_f; txclav_f <= next_txclav_f;
		end
	end

	// ----------------------------------------
	// pace tick and credit
	// ----------------------------------------
	logic [15:0] div, next_div;
	logic [3:0]  credit, next_credit;
	logic        tick, tx_start;

	always_comb begin
		tick        = (div == 16'(PACE_DIV - 1));
		next_div    = tick ? 16'h0000 : div + 16'h0001;
		next_credit = credit;
		if (tick && !tx_start && credit != 4'(acp_pkg::PACE_MAX))
			next_credit = credit + 4'h1;
		else if (tx_start && !tick)
			next_credit = credit - 4'h1;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			div <= 16'h0000; credit <= 4'h0;
		end else begin
			div <= next_div; credit <= next_credit;
		end
	end

	// ----------------------------------------
	// cell scheduler
	// ----------------------------------------
	acp_pkg::acp_state_t state, next_state;
	logic [1:0]  phy, next_phy, phy_o, next_phy_o;
	logic [2:0]  wait_cnt, next_wait;
	logic [6:0]  cnt, next_cnt;
	logic [6:0]  eff_len;
	logic        txenb_n, next_txenb_n, txsoc, next_txsoc, rxenb_n, next_rxenb_n;
	logic [7:0]  txd, next_txd;
	logic        on, next_on;

	always_comb begin
		eff_len = cell_len;
		if (cell_len < 7'(acp_pkg::CELL_STD))
			eff_len = 7'(acp_pkg::CELL_STD);
		else if (cell_len > 7'(acp_pkg::CELL_MAX))
			eff_len = 7'(acp_pkg::CELL_MAX);
	end

	always_comb begin
		next_state = state;
		next_phy   = phy;
		next_wait  = wait_cnt;
		next_cnt   = cnt;
		tx_start   = 1'b0;
		next_on    = port_enable;
		next_phy_o = phy; // select output moves together with the enables
		case (state)
			acp_pkg::ACP_IDLE: begin
				if (on && !serial_mode) begin
					next_state = acp_pkg::ACP_POLL;
					next_wait  = 3'h0;
				end
			end
			acp_pkg::ACP_POLL: begin
				if (!on || serial_mode) begin
					next_state = acp_pkg::ACP_IDLE;
				end else if (wait_cnt != 3'(acp_pkg::SYNC_LAT + 2)) begin
					// select register, then the clav synchroniser, before clav is valid
					next_wait = wait_cnt + 3'h1;
				end else if (rxclav_f) begin
					next_state = acp_pkg::ACP_RX;
					next_cnt   = 7'h00;
				end else if (txclav_f && tx_cell_avail && credit != 4'h0) begin
					next_state = acp_pkg::ACP_TX;
					next_cnt   = 7'h00;
					tx_start   = 1'b1;
				end else begin
					next_phy  = (phy == num_phy) ? 2'h0 : phy + 2'h1;
					next_wait = 3'h0;
				end
			end
			acp_pkg::ACP_RX, acp_pkg::ACP_TX: begin
				// whole cell in one burst, one handshake per cell
				next_cnt = cnt + 7'h01;
				if (cnt == eff_len - 7'h01) begin
					next_state = acp_pkg::ACP_POLL;
					next_wait  = 3'h0;
					next_phy   = (phy == num_phy) ? 2'h0 : phy + 2'h1;
				end
			end
			default: next_state = acp_pkg::ACP_IDLE;
		endcase
		tx_ready     = (state == acp_pkg::ACP_TX);
		next_txenb_n = !(state == acp_pkg::ACP_TX);
		next_txsoc   = (state == acp_pkg::ACP_TX) && (cnt == 7'h00);
		next_txd     = (state == acp_pkg::ACP_TX) ? tx_data : 8'h00;
		next_rxenb_n = !(state == acp_pkg::ACP_RX);
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state <= acp_pkg::ACP_IDLE; phy <= 2'h0; wait_cnt <= 3'h0; cnt <= 7'h00;
			phy_o <= 2'h0;
			txenb_n <= 1'b1; txsoc <= 1'b0; txd <= 8'h00; rxenb_n <= 1'b1; on <= 1'b0;
		end else begin
			state <= next_state; phy <= next_phy; wait_cnt <= next_wait; cnt <= next_cnt;
			txenb_n <= next_txenb_n; txsoc <= next_txsoc; txd <= next_txd;
			rxenb_n <= next_rxenb_n; on <= next_on; phy_o <= next_phy_o;
		end
	end

	assign utp_txdata     = txd;
	assign utp_txsoc      = txsoc;
	assign utp_txenb_n    = txenb_n;
	assign utp_rxenb_n    = rxenb_n;
	assign utp_phy_addr   = phy_o;
	assign eth_disable    = on;
	assign portd_cell_sel = on;

	// ----------------------------------------
	// receive byte path
	// ----------------------------------------
	acp_ser_if ser ();
	acp_ser_bytes u_ser (
		.clock     (clock),
		.nrst      (nrst),
		.ser_clk   (ser_clk),
		.ser_rxd   (ser_rxd),
		.ser_bsync (ser_bsync),
		.ser_fsync (ser_fsync),
		.bytes     (ser.src)
	);

	logic [3:0] pipe, next_pipe;
	logic [1:0] phy_p [4], next_phy_p [4];
	logic [6:0] bcnt, next_bcnt;
	logic       in_v, in_sop;
	logic [7:0] in_d;
	logic [7:0] rxd, next_rxd;
	logic       rxv, next_rxv, rxs, next_rxs;
	logic [1:0] rxp, next_rxp;

	always_comb begin
		// phy answers one cycle after enable, then three synchroniser stages
		next_pipe     = {pipe[2:0], !rxenb_n};
		next_phy_p[0] = phy_o;
		next_phy_p[1] = phy_p[0];
		next_phy_p[2] = phy_p[1];
		next_phy_p[3] = phy_p[2];
		if (serial_mode) begin
			in_v   = ser.valid;
			in_d   = ser.data;
			in_sop = ser.valid && ser.frame && bcnt == 7'h00;
		end else begin
			in_v   = pipe[3];
			in_d   = s3[7:0];
			in_sop = pipe[3] && s3[8];
		end
		next_bcnt = bcnt;
		if (in_v)
			next_bcnt = (in_sop || bcnt == eff_len - 7'h01) ? (in_sop ? 7'h01 : 7'h00)
				: bcnt + 7'h01;
		next_rxd = in_v ? in_d : rxd;
		next_rxv = in_v;
		next_rxs = in_v && (in_sop || bcnt == 7'h00);
		next_rxp = serial_mode ? 2'h0 : phy_p[3];
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			pipe <= 4'h0; bcnt <= 7'h00; rxd <= 8'h00; rxv <= 1'b0; rxs <= 1'b0; rxp <= 2'h0;
			phy_p[0] <= 2'h0; phy_p[1] <= 2'h0; phy_p[2] <= 2'h0; phy_p[3] <= 2'h0;
		end else begin
			pipe <= next_pipe; bcnt <= next_bcnt; rxd <= next_rxd; rxv <= next_rxv;
			rxs <= next_rxs; rxp <= next_rxp; phy_p <= next_phy_p;
		end
	end

	assign rx_data  = rxd;
	assign rx_valid = rxv;
	assign rx_sop   = rxs;
	assign rx_phy   = rxp;

	// ----------------------------------------
	// receive connection lookup
	// ----------------------------------------
	logic [23:0] tkey [NUM_CONN], next_tkey [NUM_CONN];
	logic        tval [NUM_CONN], next_tval [NUM_CONN];
	logic [23:0] key, next_key;
	logic        done, next_done, hit, next_hit, xreq, next_xreq, xcam, next_xcam;
	logic [4:0]  idx, next_idx;
	logic [15:0] xaddr, next_xaddr;

	always_comb begin
		next_tkey = tkey;
		next_tval = tval;
		if (tbl_we && 32'(tbl_idx) < NUM_CONN) begin
			next_tkey[tbl_idx] = tbl_key;
			next_tval[tbl_idx] = tbl_entry_valid;
		end
		next_key = key;
		if (rxv && bcnt <= 7'(acp_pkg::HDR_LAST + 1))
			next_key = {key[15:0], rxd};
		next_done  = 1'b0;
		next_hit   = hit;
		next_idx   = idx;
		next_xreq  = 1'b0;
		next_xcam  = xcam;
		next_xaddr = xaddr;
		if (rxv && bcnt == 7'(acp_pkg::HDR_LAST + 1)) begin
			next_done = 1'b1;
			next_hit  = 1'b0;
			next_idx  = 5'h00;
			for (int i = 0; i < NUM_CONN; i++) begin
				if (tval[i] && tkey[i] == {key[15:0], rxd} && !next_hit) begin
					next_hit = 1'b1;
					next_idx = 5'(i);
				end
			end
			next_xreq  = !next_hit;
			next_xcam  = ext_cam_mode;
			next_xaddr = {key[15:8] ^ rxd, key[7:0]};
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_CONN; i++) begin
				tkey[i] <= 24'h000000;
				tval[i] <= 1'b0;
			end
			key <= 24'h000000; done <= 1'b0; hit <= 1'b0; idx <= 5'h00;
			xreq <= 1'b0; xcam <= 1'b0; xaddr <= 16'h0000;
		end else begin
			tkey <= next_tkey; tval <= next_tval; key <= next_key; done <= next_done;
			hit <= next_hit; idx <= next_idx; xreq <= next_xreq; xcam <= next_xcam;
			xaddr <= next_xaddr;
		end
	end

	assign conn_done = done;
	assign conn_hit  = hit;
	assign conn_idx  = idx;
	assign ext_req   = xreq;
	assign ext_cam   = xcam;
	assign ext_addr  = xaddr;
	assign ext_key   = key;
endmodule : acp_cell_port

// >>> tb/acp_cell_port_checker.sv
`timescale 1ns/100ps
module acp_cell_port_checker (
	input wire logic       clock,          // clock
	input wire logic       nrst,           // reset
	input wire logic       port_enable,    // port on
	input wire logic [6:0] cell_len,       // cell bytes
	input wire logic [7:0] utp_txdata,     // tx byte
	input wire logic       utp_txsoc,      // tx soc
	input wire logic       utp_txenb_n,    // tx enable
	input wire logic       utp_rxenb_n,    // rx enable
	input wire logic [1:0] utp_phy_addr,   // phy select
	input wire logic [7:0] tx_data,        // source byte
	input wire logic       tx_ready,       // byte taken
	input wire logic       rx_valid,       // rx pulse
	input wire logic       rx_sop,         // rx first
	input wire logic       eth_disable,    // eth off
	input wire logic       portd_cell_sel  // port mux
);
	logic [6:0] tx_run;
	logic [6:0] rx_run;
	logic [6:0] len_ok;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// length after clamping to the legal range
	always_comb len_ok = (cell_len < 7'h35) ? 7'h35 : ((cell_len > 7'h40) ? 7'h40 : cell_len);
	always_ff @(posedge clock) begin
		tx_run <= (!nrst || utp_txenb_n) ? 7'h00 : tx_run + 7'h01;
		rx_run <= (!nrst || utp_rxenb_n) ? 7'h00 : rx_run + 7'h01;
	end
	reset_idle_a: assert property (disable iff (1'b0) !nrst |=> utp_txenb_n && utp_rxenb_n)
		else $error("enable active after reset");
	eth_follow_a: assert property (eth_disable == $past(port_enable) && portd_cell_sel == eth_disable)
		else $error("ethernet block or port mux wrong");
	one_dir_a: assert property (!(!utp_txenb_n && !utp_rxenb_n))
		else $error("both directions active");
	tx_len_a: assert property ($rose(utp_txenb_n) |-> tx_run == len_ok)
		else $error("tx cell length wrong");
	rx_len_a: assert property ($rose(utp_rxenb_n) |-> rx_run == len_ok)
		else $error("rx cell length wrong");
	tx_soc_a: assert property (utp_txsoc == $fell(utp_txenb_n))
		else $error("tx soc not on first byte");
	tx_data_a: assert property (tx_ready |=> !utp_txenb_n && utp_txdata == $past(tx_data))
		else $error("tx byte not passed on");
	addr_hold_a: assert property ($past(!utp_txenb_n || !utp_rxenb_n) && (!utp_txenb_n || !utp_rxenb_n)
		|-> $stable(utp_phy_addr)) else $error("phy select moved in cell");
	sop_valid_a: assert property (rx_sop |-> rx_valid)
		else $error("rx sop without byte");
endmodule : acp_cell_port_checker

bind acp_cell_port acp_cell_port_checker u_chk (.clock(clock), .nrst(nrst),
	.port_enable(port_enable), .cell_len(cell_len), .utp_txdata(utp_txdata),
	.utp_txsoc(utp_txsoc), .utp_txenb_n(utp_txenb_n), .utp_rxenb_n(utp_rxenb_n),
	.utp_phy_addr(utp_phy_addr), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
	.rx_sop(rx_sop), .eth_disable(eth_disable), .portd_cell_sel(portd_cell_sel));

// >>> tb/acp_phy_model.sv
`timescale 1ns/100ps
module acp_phy_model (
	input  wire logic       clock,    // clock
	input  wire logic [3:0] rx_push,  // phy gets a cell
	input  wire logic       tx_room,  // phys can take a cell
	input  wire logic [1:0] phy_addr, // select
	input  wire logic       rxenb_n,  // rx enable
	output logic      [7:0] rxdata,   // rx byte
	output logic            rxsoc,    // rx soc
	output logic            rxclav,   // cell held
	output logic            txclav,   // room
	input  wire logic       txenb_n,  // tx enable
	input  wire logic       txsoc,    // tx soc
	input  wire logic [7:0] txdata,   // tx byte
	output logic      [6:0] tx_count, // bytes of last tx cell
	output logic      [7:0] tx_first  // first byte of last tx cell
);
	logic [3:0] pend;
	logic [5:0] cnt;
	initial begin
		pend = 4'h0;
		cnt = 6'h00;
		rxdata = 8'h00;
		rxsoc = 1'b0;
		tx_count = 7'h00;
		tx_first = 8'h00;
	end
	assign rxclav = pend[phy_addr];
	assign txclav = tx_room;
	always @(posedge clock) begin
		// cell stays held until the port takes it
		pend <= (pend | rx_push) & ~((!rxenb_n && cnt == 6'h00) ? (4'h1 << phy_addr) : 4'h0);
		if (!rxenb_n) begin
			rxdata <= {phy_addr, cnt};
			rxsoc <= (cnt == 6'h00);
			cnt <= cnt + 6'h01;
		end else begin
			rxdata <= ~rxdata;
			rxsoc <= 1'b0;
			cnt <= 6'h00;
		end
		if (!txenb_n) begin
			tx_count <= txsoc ? 7'h01 : tx_count + 7'h01;
			if (txsoc) tx_first <= txdata;
		end
	end
endmodule : acp_phy_model

// >>> tb/test_atm_cell_port.sv
`timescale 1ns/100ps
module test_atm_cell_port;
	logic clock, nrst, port_enable, ext_cam_mode, tx_cell_avail, tx_room, tbl_we;
	logic [1:0] num_phy;
	logic [6:0] cell_len;
	logic [3:0] rx_push;
	logic [4:0] tbl_idx;
	logic [23:0] tbl_key;
	logic [7:0] tx_idx;
	logic serial_mode, tbl_ok, ser_clk, ser_rxd, ser_bsync, ser_fsync;
	logic [7:0] sop_data;
	logic [15:0] addr_v;
	wire [15:0] ext_addr;
	wire [7:0] utp_txdata, utp_rxdata, rx_data, m_first;
	wire utp_txsoc, utp_txenb_n, utp_txclav, utp_rxsoc, utp_rxenb_n, utp_rxclav, tx_ready;
	wire rx_valid, rx_sop, conn_done, conn_hit, ext_req, ext_cam;
	wire [1:0] utp_phy_addr, rx_phy;
	wire [4:0] conn_idx;
	wire [6:0] m_count;
	wire [23:0] ext_key;
	int bad_count, n_checks, cyc, rx_n, sop_n, i;
	logic [1:0] sop_phy;
	logic hit_v, cam_v;
	logic [4:0] idx_v;
	logic [23:0] key_v;
	acp_cell_port #(.PACE_DIV(2), .NUM_CONN(32)) u_dut (.clock(clock), .nrst(nrst),
		.port_enable(port_enable), .serial_mode(serial_mode), .num_phy(num_phy), .cell_len(cell_len),
		.ext_cam_mode(ext_cam_mode), .utp_txdata(utp_txdata), .utp_txsoc(utp_txsoc),
		.utp_txenb_n(utp_txenb_n), .utp_txclav(utp_txclav), .utp_rxdata(utp_rxdata),
		.utp_rxsoc(utp_rxsoc), .utp_rxenb_n(utp_rxenb_n), .utp_rxclav(utp_rxclav),
		.utp_phy_addr(utp_phy_addr), .ser_clk(ser_clk), .ser_rxd(ser_rxd), .ser_bsync(ser_bsync),
		.ser_fsync(ser_fsync), .tx_cell_avail(tx_cell_avail), .tx_data(tx_idx), .tx_ready(tx_ready),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_sop(rx_sop), .rx_phy(rx_phy),
		.tbl_we(tbl_we), .tbl_idx(tbl_idx), .tbl_key(tbl_key), .tbl_entry_valid(tbl_ok),
		.conn_done(conn_done), .conn_hit(conn_hit), .conn_idx(conn_idx), .ext_req(ext_req),
		.ext_cam(ext_cam), .ext_addr(ext_addr), .ext_key(ext_key), .eth_disable(),
		.portd_cell_sel());
	acp_phy_model u_phy (.clock(clock), .rx_push(rx_push), .tx_room(tx_room),
		.phy_addr(utp_phy_addr), .rxenb_n(utp_rxenb_n), .rxdata(utp_rxdata), .rxsoc(utp_rxsoc),
		.rxclav(utp_rxclav), .txclav(utp_txclav), .txenb_n(utp_txenb_n), .txsoc(utp_txsoc),
		.txdata(utp_txdata), .tx_count(m_count), .tx_first(m_first));
	initial forever #50 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (tx_ready === 1'b1) tx_idx <= tx_idx + 8'h01;
		if (rx_valid === 1'b1) rx_n++;
		if (rx_sop === 1'b1) begin
			sop_n++;
			sop_phy <= rx_phy;
			sop_data <= rx_data;
		end
		if (conn_done === 1'b1) {hit_v, idx_v} <= {conn_hit, conn_idx};
		if (ext_req === 1'b1) {cam_v, key_v, addr_v} <= {ext_cam, ext_key, ext_addr};
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic run_rx(input logic [1:0] phy, input logic [6:0] len, input bit hold);
		rx_n = 0;
		sop_n = 0;
		cell_len = len;
		rx_push = 4'h1 << phy;
		@(negedge clock);
		rx_push = 4'h0;
		if (hold) begin
			repeat (30) @(negedge clock);
			check(rx_n == 0 && utp_rxenb_n === 1'b1, "cell taken while port off");
			port_enable = 1'b1;
		end
		for (i = 0; i < 400 && rx_n < len; i++) @(negedge clock);
		repeat (4) @(negedge clock);
		check(rx_n == len && sop_n == 1, "rx byte count");
		check(sop_phy === phy, "rx phy");
		check(sop_data === {phy, 6'h00}, "rx first byte");
	endtask : run_rx
	task automatic run_tx(input logic [6:0] len);
		cell_len = len;
		tx_idx = 8'h10;
		tx_cell_avail = 1'b1;
		for (i = 0; i < 300 && tx_ready !== 1'b1; i++) @(negedge clock);
		tx_cell_avail = 1'b0;
		for (i = 0; i < 300 && utp_txenb_n !== 1'b0; i++) @(negedge clock);
		for (i = 0; i < 300 && utp_txenb_n !== 1'b1; i++) @(negedge clock);
		@(negedge clock);
		check(m_count === len && m_first === 8'h10, "tx cell at phy");
		check(tx_idx === 8'h10 + {1'b0, len}, "tx bytes taken");
	endtask : run_tx
	task automatic t_prio();
		port_enable = 1'b0;
		num_phy = 2'h0;
		// select is frozen while idle, so rx and tx meet at one poll
		repeat (10) @(negedge clock);
		rx_push = 4'h1 << utp_phy_addr;
		tx_cell_avail = 1'b1;
		@(negedge clock);
		rx_push = 4'h0;
		repeat (10) @(negedge clock);
		port_enable = 1'b1;
		for (i = 0; i < 300 && utp_rxenb_n !== 1'b0 && utp_txenb_n !== 1'b0; i++) @(negedge clock);
		check(utp_rxenb_n === 1'b0 && utp_txenb_n === 1'b1, "receive not first");
		tx_cell_avail = 1'b0;
		run_tx(7'h35);
	endtask : t_prio
	task automatic t_conn();
		tbl_we = 1'b1;
		tbl_ok = 1'b1;
		{tbl_idx, tbl_key} = {5'h05, 24'h414243};
		@(negedge clock);
		{tbl_idx, tbl_key} = {5'h1f, 24'h818283};
		@(negedge clock);
		// entry written but not in use: must not match
		{tbl_ok, tbl_idx, tbl_key} = {1'b0, 5'h00, 24'h010203};
		@(negedge clock);
		tbl_we = 1'b0;
		run_rx(2'h1, 7'h35, 1'b0);
		check(hit_v === 1'b1 && idx_v === 5'h05, "table hit");
		run_rx(2'h2, 7'h35, 1'b0);
		check(hit_v === 1'b1 && idx_v === 5'h1f, "table hit last entry");
		ext_cam_mode = 1'b1;
		run_rx(2'h3, 7'h35, 1'b0);
		check(cam_v === 1'b1 && key_v === 24'hc1c2c3, "cam lookup");
		ext_cam_mode = 1'b0;
		run_rx(2'h0, 7'h35, 1'b0);
		check(cam_v === 1'b0 && key_v === 24'h010203, "compressed lookup");
		check(hit_v === 1'b0 && addr_v === 16'h0202, "unused entry or address");
	endtask : t_conn
	task automatic t_serial();
		logic [7:0] b;
		serial_mode = 1'b1;
		cell_len = 7'h35;
		rx_n = 0;
		sop_n = 0;
		for (int j = 0; j < 53; j++) begin
			b = 8'ha0 ^ 8'(j);
			for (int k = 7; k >= 0; k--) begin
				{ser_rxd, ser_bsync, ser_fsync} = {b[k], k == 7, j == 0 && k == 7};
				ser_clk = 1'b0;
				repeat (4) @(negedge clock);
				ser_clk = 1'b1;
				repeat (4) @(negedge clock);
			end
		end
		repeat (8) @(negedge clock);
		check(rx_n == 53 && sop_n == 1, "serial byte count");
		check(sop_data === 8'ha0 && sop_phy === 2'h0, "serial first byte");
		serial_mode = 1'b0;
	endtask : t_serial
	initial begin
		clock = 1'b0;
		{nrst, port_enable, ext_cam_mode, tx_cell_avail, tx_room, tbl_we} = 6'h00;
		{serial_mode, tbl_ok, ser_clk, ser_rxd, ser_bsync, ser_fsync} = 6'h00;
		{num_phy, cell_len, rx_push, tbl_idx, tbl_key, tx_idx} = '0;
		{bad_count, n_checks, cyc, rx_n, sop_n} = '0;
		repeat (3) @(negedge clock);
		nrst = 1'b1;
		tx_room = 1'b1;
		run_rx(2'h0, 7'h35, 1'b1);
		num_phy = 2'h3;
		run_rx(2'h3, 7'h40, 1'b0);
		run_rx(2'h1, 7'h35, 1'b0);
		run_rx(2'h2, 7'h40, 1'b0);
		run_tx(7'h35);
		run_tx(7'h40);
		t_prio();
		num_phy = 2'h3;
		t_conn();
		t_serial();
		final_report();
	end
endmodule : test_atm_cell_port
